// ### design/usw_wire_ctrl.sv
// Wire-mode output control, flags and clock hold for the universal serial unit
//
// Overview of operation
// R1: Request interrupt when wrap flag, wrap enable and global enable are all set.
// R2: A wrap flag already pending requests at once when both enables rise.
// R3: Wire mode changes pin outputs and start detection; data and clock inputs always work.
// R4: Data input sampling and clock edge detection run in every wire mode.
// R5: Mode 00 disables serial outputs, clock hold, start detector; pins act as port.
// R6: Three-wire: serial data output replaces port latch; direction latch still decides.
// R7: Three-wire: data output pin as input takes pull-up from its port latch.
// R8: Three-wire: data input and clock pins keep ordinary port behaviour.
// R9: A three-wire master toggles the clock latch in software, pin as output.
// R10: Two-wire: SDA and SCL are open-collector, pulled low or released only.
// R11: Two-wire: SDA and SCL drivers enabled only by their direction latch bits.
// R12: Two-wire SDA pulled low when shift output bit or port latch is zero.
// R13: Two-wire SCL pulled low when port latch zero or start hold active.
// R14: A start condition holds SCL low until software clears the start flag.
// R15: Pull-ups on SDA and SCL are off in either two-wire mode.
// R16: Mode 11 also holds SCL low from counter wrap until wrap flag cleared.
// R17: In two-wire modes the data input pin is SDA, the clock pin SCL.
// R18: Wrap flag sets on counter roll from 15 to 0; cleared by writing one.
// R19: Start flag sets on start condition in two-wire mode; cleared by writing one.
// R20: Toggle strobe inverts the clock pin latch; it is write-only, reads zero.
// R21: SCL is released only when every low request has ended.
`timescale 1ns/1ps
module usw_wire_ctrl
    import usw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] wire_mode_select,
    input wire logic counter_wrap_irq_enable,
    input wire logic global_irq_enable,
    input wire logic [2:0] port_direction_latch,
    input wire logic latch_wr_en,
    input wire logic [2:0] latch_wr_data,
    input wire logic clock_pin_toggle_strobe,
    input wire logic shift_msb,
    input wire logic counter_wrap_event,
    input wire logic wrap_flag_clear,
    input wire logic start_flag_clear,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    output logic [2:0] pin_pullup,
    output logic [2:0] port_output_latch,
    output logic counter_wrap_flag,
    output logic start_seen_flag,
    output logic wrap_irq_req,
    output logic serial_in_sample,
    output logic clk_pin_rise,
    output logic clk_pin_fall
);

    // Synchronised pin levels and their previous values
    logic [2:0] pin_s;
    logic sda_prev_r;
    logic scl_prev_r;

    // Held state
    logic [2:0] latch_r;
    logic [2:0] latch_nxt;
    logic wrap_flag_r;
    logic wrap_flag_nxt;
    logic start_flag_r;
    logic start_flag_nxt;
    logic irq_r;
    logic irq_nxt;
    logic din_r;
    logic rise_r;
    logic fall_r;
    logic [2:0] out_r;
    logic [2:0] out_nxt;
    logic [2:0] oe_r;
    logic [2:0] oe_nxt;
    logic [2:0] pu_r;
    logic [2:0] pu_nxt;

    // Pins are asynchronous to mclk, including the link clock
    usw_sync #(
        .WIDTH(USW_PINS)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in(pin_in),
        .sync_out(pin_s)
    );

    // Mode decode
    wire two_wire = usw_is_two_wire(wire_mode_select); // R17
    wire three_wire = usw_is_three_wire(wire_mode_select);
    wire ovf_hold_mode = wire_mode_select == USW_WM_TWO_HOLD; // R16

    // Pin views; the same pins serve as SDA and SCL in two-wire modes
    wire sda_now = pin_s[USW_PIN_SDA]; // R17
    wire scl_now = pin_s[USW_PIN_SCL]; // R17

    // Edge detection is mode-independent so external clocking always works
    wire scl_rise = scl_now & ~scl_prev_r; // R3 R4
    wire scl_fall = ~scl_now & scl_prev_r; // R4

    // Start detector only armed in two-wire modes: SDA falls while SCL high
    wire start_event = two_wire & scl_now & scl_prev_r & sda_prev_r & ~sda_now; // R5 R19

    // Latch update: write first, toggle strobe then inverts the clock bit
    wire [2:0] latch_written = latch_wr_en ? latch_wr_data : latch_r;
    wire [2:0] toggle_mask = {clock_pin_toggle_strobe, 2'h0};
    assign latch_nxt = latch_written ^ toggle_mask; // R9 R20

    // Sticky flags; a set in the clearing cycle wins
    assign wrap_flag_nxt = counter_wrap_event | (wrap_flag_r & ~wrap_flag_clear); // R18
    assign start_flag_nxt = start_event | (start_flag_r & ~start_flag_clear); // R14 R19

    // Level request, so a pending flag fires as soon as both enables rise
    assign irq_nxt = wrap_flag_r & counter_wrap_irq_enable & global_irq_enable; // R1 R2

    // SCL low requests, any one of them keeps the line down
    wire start_hold = two_wire & start_flag_r; // R14
    wire ovf_hold = ovf_hold_mode & wrap_flag_r; // R16
    wire scl_low = ~latch_r[USW_PIN_SCL] | start_hold | ovf_hold; // R13 R21
    wire sda_low = ~shift_msb | ~latch_r[USW_PIN_SDA]; // R12

    // Ordinary port behaviour, used by any pin the mode does not claim
    wire [2:0] port_out = latch_r; // R5 R8
    wire [2:0] port_oe = port_direction_latch;
    wire [2:0] port_pu = ~port_direction_latch & latch_r;

    // Two-wire open-collector drive: output level always zero
    wire sda_oe_tw = port_direction_latch[USW_PIN_SDA] & sda_low; // R10 R11 R12
    wire scl_oe_tw = port_direction_latch[USW_PIN_SCL] & scl_low; // R10 R11 R13

    // Three-wire data output overrides the latch but keeps direction
    wire [2:0] tw3_out = {latch_r[USW_PIN_SCL], shift_msb, latch_r[USW_PIN_SDA]}; // R6 R8

    // Two-wire pin values: SDA and SCL open-collector, data output pin as port
    wire [2:0] tw2_out = {1'h0, latch_r[USW_PIN_DO], 1'h0}; // R10
    wire [2:0] tw2_oe = {scl_oe_tw, port_direction_latch[USW_PIN_DO], sda_oe_tw};
    wire [2:0] tw2_pu = {1'h0, port_pu[USW_PIN_DO], 1'h0}; // R15

    // Output selection by mode; inputs are never steered here
    always_comb begin
        out_nxt = port_out;
        oe_nxt = port_oe;
        pu_nxt = port_pu;
        unique case (wire_mode_select)
            USW_WM_OFF: begin
                out_nxt = port_out; // R5
            end
            USW_WM_THREE: begin
                out_nxt = tw3_out; // R6
                pu_nxt = port_pu; // R7
            end
            USW_WM_TWO, USW_WM_TWO_HOLD: begin
                out_nxt = tw2_out;
                oe_nxt = tw2_oe;
                pu_nxt = tw2_pu;
            end
        endcase
    end

    // Pin history for edge and start detection
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sda_prev_r <= 1'h1;
            scl_prev_r <= 1'h1;
        end else begin
            sda_prev_r <= sda_now;
            scl_prev_r <= scl_now;
        end
    end

    // Port output latch, owned here so the toggle strobe can act on it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            latch_r <= USW_LATCH_RST;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // Flags and interrupt request
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wrap_flag_r <= USW_FLAG_RST;
            start_flag_r <= USW_FLAG_RST;
            irq_r <= 1'h0;
        end else begin
            wrap_flag_r <= wrap_flag_nxt;
            start_flag_r <= start_flag_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Sampled data input and clock edges, valid with outputs disabled too
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            din_r <= 1'h0;
            rise_r <= 1'h0;
            fall_r <= 1'h0;
        end else begin
            din_r <= sda_now; // R3 R4
            rise_r <= scl_rise;
            fall_r <= scl_fall;
        end
    end

    // Registered pin drive; costs one cycle but keeps outputs glitch free
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            out_r <= USW_PIN_RST;
            oe_r <= USW_PIN_RST;
            pu_r <= USW_PIN_RST;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
        end
    end

    assign pin_out = out_r;
    assign pin_oe = oe_r;
    assign pin_pullup = pu_r;
    assign port_output_latch = latch_r;
    assign counter_wrap_flag = wrap_flag_r;
    assign start_seen_flag = start_flag_r;
    assign wrap_irq_req = irq_r;
    assign serial_in_sample = din_r;
    assign clk_pin_rise = rise_r;
    assign clk_pin_fall = fall_r;

    // Interrupt follows a pending flag once both enables are high
    a_irq_when_pending: assert property ( // R1
        @(posedge mclk) disable iff (!rst_b)
        wrap_flag_r && counter_wrap_irq_enable && global_irq_enable |=> wrap_irq_req)
        else $error("wrap interrupt not requested");

    // Late enable on a pending flag fires on the next edge
    a_irq_late_enable: assert property ( // R2
        @(posedge mclk) disable iff (!rst_b)
        wrap_flag_r && $rose(counter_wrap_irq_enable) && global_irq_enable
        && !wrap_flag_clear |=> wrap_irq_req)
        else $error("pending wrap interrupt delayed");

    // No request without the local enable
    a_irq_gated: assert property ( // R1
        @(posedge mclk) disable iff (!rst_b)
        !counter_wrap_irq_enable |=> !wrap_irq_req)
        else $error("wrap interrupt without enable");

    // Wrap flag set and sticky until written one
    a_wrap_flag_sticky: assert property ( // R18
        @(posedge mclk) disable iff (!rst_b)
        (counter_wrap_event || wrap_flag_r) && !wrap_flag_clear
        |=> counter_wrap_flag)
        else $error("wrap flag lost");

    // Start condition sets the start flag
    a_start_flag_set: assert property ( // R19
        @(posedge mclk) disable iff (!rst_b)
        start_event |=> start_seen_flag)
        else $error("start flag not set");

    // Two-wire pins never drive high and have no pull-up
    a_two_wire_drive: assert property ( // R10
        @(posedge mclk) disable iff (!rst_b)
        usw_is_two_wire(wire_mode_select) |=> !pin_out[USW_PIN_SDA]
        && !pin_out[USW_PIN_SCL] && !pin_pullup[USW_PIN_SDA] && !pin_pullup[USW_PIN_SCL])
        else $error("two-wire pin driven high or pulled up");

    // Start hold keeps SCL low while its direction bit is set
    a_scl_start_hold: assert property ( // R14
        @(posedge mclk) disable iff (!rst_b)
        usw_is_two_wire(wire_mode_select) && start_seen_flag
        && port_direction_latch[USW_PIN_SCL] |=> pin_oe[USW_PIN_SCL])
        else $error("SCL not held after start");

    // Overflow hold in mode 11
    a_scl_ovf_hold: assert property ( // R16
        @(posedge mclk) disable iff (!rst_b)
        wire_mode_select == USW_WM_TWO_HOLD && counter_wrap_flag
        && port_direction_latch[USW_PIN_SCL] |=> pin_oe[USW_PIN_SCL])
        else $error("SCL not held after overflow");

    // Port mode mirrors the latches
    a_off_mode_port: assert property ( // R5
        @(posedge mclk) disable iff (!rst_b)
        wire_mode_select == USW_WM_OFF |=> pin_oe == $past(port_direction_latch)
        && pin_out == $past(port_output_latch))
        else $error("port pins altered in off mode");

    // Three-wire data output carries the shift output bit
    a_three_wire_do: assert property ( // R6
        @(posedge mclk) disable iff (!rst_b)
        three_wire |=> pin_out[USW_PIN_DO] == $past(shift_msb))
        else $error("data output not from shift bit");

    // Toggle strobe inverts the clock latch
    a_toggle_inverts: assert property ( // R20
        @(posedge mclk) disable iff (!rst_b)
        clock_pin_toggle_strobe && !latch_wr_en
        |=> port_output_latch[USW_PIN_SCL] != $past(port_output_latch[USW_PIN_SCL]))
        else $error("toggle strobe did not invert clock latch");

    // Two-wire SDA pulled low by a zero shift bit or latch bit
    a_sda_drive_low: assert property ( // R12
        @(posedge mclk) disable iff (!rst_b)
        two_wire |=> pin_oe[USW_PIN_SDA]
        == $past(port_direction_latch[USW_PIN_SDA] & (~shift_msb | ~latch_r[USW_PIN_SDA])))
        else $error("SDA drive does not follow shift and latch bits");

    // SCL let go once no low request is left
    a_scl_release: assert property ( // R21
        @(posedge mclk) disable iff (!rst_b)
        two_wire && latch_r[USW_PIN_SCL] && !start_flag_r && !ovf_hold
        |=> !pin_oe[USW_PIN_SCL])
        else $error("SCL held with no low request");

    // Two-wire drivers need their direction bits
    a_oe_needs_dir: assert property ( // R11
        @(posedge mclk) disable iff (!rst_b)
        two_wire |=> (pin_oe & ~$past(port_direction_latch)) == 3'h0)
        else $error("two-wire driver on without direction bit");

    // Three-wire input pins take their pull-up from the latch
    a_three_wire_pullup: assert property ( // R7
        @(posedge mclk) disable iff (!rst_b)
        three_wire |=> pin_pullup == $past(~port_direction_latch & latch_r))
        else $error("three-wire pull-up not from latch");

    // No start flag outside two-wire modes
    a_start_off_modes: assert property ( // R5
        @(posedge mclk) disable iff (!rst_b)
        !two_wire && !start_flag_r |=> !start_seen_flag)
        else $error("start flag set outside two-wire mode");

    // Writing one clears the start flag
    a_start_flag_clear: assert property ( // R19
        @(posedge mclk) disable iff (!rst_b)
        start_flag_r && start_flag_clear && !start_event |=> !start_seen_flag)
        else $error("start flag not cleared");

    // A wrap in the clearing cycle keeps the flag
    a_wrap_set_wins: assert property ( // R18
        @(posedge mclk) disable iff (!rst_b)
        counter_wrap_event && wrap_flag_clear |=> counter_wrap_flag)
        else $error("wrap flag lost to clear");

endmodule

// ### design/usw_pkg.sv
// Shared constants, mode codes and decode helpers for the wire-mode pin control
package usw_pkg;

    // Pin slots within the three-pin group
    localparam int USW_PINS = 3;
    localparam int USW_PIN_SDA = 0;
    localparam int USW_PIN_DO = 1;
    localparam int USW_PIN_SCL = 2;

    // Synchroniser depth for pin inputs
    localparam int USW_SYNC_STAGES = 2;

    // Reset values
    localparam logic [2:0] USW_LATCH_RST = 3'h0;
    localparam logic [2:0] USW_PIN_RST = 3'h0;
    localparam logic USW_FLAG_RST = 1'h0;

    // Wire mode field encodings
    typedef enum logic [1:0] {
        USW_WM_OFF = 2'h0,
        USW_WM_THREE = 2'h1,
        USW_WM_TWO = 2'h2,
        USW_WM_TWO_HOLD = 2'h3
    } usw_mode_e;

    // Either two-wire flavour selected
    function automatic logic usw_is_two_wire(input logic [1:0] mode);
        return mode[1];
    endfunction

    // Three-wire flavour selected
    function automatic logic usw_is_three_wire(input logic [1:0] mode);
        return mode == USW_WM_THREE;
    endfunction

endpackage

// ### design/usw_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module usw_sync
    import usw_pkg::*;
#(
    parameter int WIDTH = USW_PINS
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_r <= '1; // Idle bus level, so no false edge after reset
            sync_r <= '1;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// ### bench/usw_bus_peer.sv
// Behavioural serial bus peer that only ever pulls the shared lines low
`timescale 1ns/1ps
module usw_bus_peer (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    output logic [2:0] pin_in
);
    logic [2:0] pk_low = 3'h0;
    // Wire level: block driver first, else peer pull-down, else external pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~pk_low);
    // Start: data falls while clock high, then clock low, then both let go
    task automatic start_cond();
        #3;
        pk_low[0] = 1'b1;
        #62.5;
        pk_low[2] = 1'b1;
        #62.5;
        pk_low[0] = 1'b0;
        #62.5;
        pk_low[2] = 1'b0;
        #62.5;
    endtask
    // Eight clocks, MSB first; data moves while clock is low to avoid a start, and is let go after the last clock release
    task automatic clocks(input logic [7:0] d);
        #3;
        for (int i = 7; i >= 0; i--) begin
            pk_low[2] = 1'b1;
            #20;
            pk_low[0] = ~d[i];
            #42.5;
            pk_low[2] = 1'b0;
            #62.5;
        end
        pk_low = 3'h0;
    endtask
endmodule

// ### bench/tb_usw_wire_ctrl.sv
// Self-checking bench for the wire-mode pin control block
`timescale 1ns/1ps
module tb_usw_wire_ctrl
    import usw_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] mode = 2'h0;
    logic en = 1'b0;
    logic gie = 1'b0;
    logic [2:0] dir = 3'h0;
    logic lwe = 1'b0;
    logic [2:0] lwd = 3'h0;
    logic tgl = 1'b0;
    logic sh = 1'b0;
    logic wev = 1'b0;
    logic wclr = 1'b0;
    logic sclr = 1'b0;
    logic look = 1'b0;
    logic edg = 1'b0;
    logic [2:0] lm = 3'h0;
    logic sf = 1'b0;
    logic wf = 1'b0;
    logic [2:0] p_in, p_out, p_oe, p_pu, p_lat;
    logic o_wf, o_sf, o_irq, o_smp, o_rise, o_fall;
    logic [14:0] q[$];
    logic dq[$];
    int fail_count = 0;
    int compares = 0;
    int falls = 0;
    integer seed = 32'hBCBD;

    initial forever #5 mclk = ~mclk;

    usw_wire_ctrl usw_wire_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .wire_mode_select(mode),
        .counter_wrap_irq_enable(en), .global_irq_enable(gie), .port_direction_latch(dir),
        .latch_wr_en(lwe), .latch_wr_data(lwd), .clock_pin_toggle_strobe(tgl),
        .shift_msb(sh), .counter_wrap_event(wev), .wrap_flag_clear(wclr),
        .start_flag_clear(sclr), .pin_in(p_in), .pin_out(p_out), .pin_oe(p_oe),
        .pin_pullup(p_pu), .port_output_latch(p_lat), .counter_wrap_flag(o_wf),
        .start_seen_flag(o_sf), .wrap_irq_req(o_irq), .serial_in_sample(o_smp),
        .clk_pin_rise(o_rise), .clk_pin_fall(o_fall));

    usw_bus_peer usw_bus_peer_inst (.pin_out(p_out), .pin_oe(p_oe), .pin_in(p_in));

    task automatic cmp(input logic [14:0] seen, input logic [14:0] expd);
        compares++;
        if (seen !== expd) begin
            fail_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expd);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Expected pin and flag snapshot from the tracked state
    function automatic logic [14:0] expv();
        logic [2:0] o;
        logic [2:0] e;
        logic [2:0] p;
        o = lm;
        e = dir;
        p = ~dir & lm;
        if (mode == USW_WM_THREE) o[1] = sh;
        if (mode[1]) begin
            o = o & 3'h2;
            p = p & 3'h2;
            e[0] = dir[0] & (~sh | ~lm[0]);
            e[2] = dir[2] & (~lm[2] | sf | (mode[0] & wf));
        end
        return {o, e, p, lm, wf, sf, wf & en & gie};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic z);
        q.push_back(z ? 15'h0 : expv());
        look <= 1'b1;
        @(posedge mclk);
        look <= 1'b0;
    endtask
    // One-cycle strobe by index: 0 wrap event, 1 wrap clear, 2 start clear, 3 toggle
    task automatic pulse(input int s);
        {tgl, sclr, wclr, wev} <= 4'h1 << s;
        @(posedge mclk);
        {tgl, sclr, wclr, wev} <= 4'h0;
    endtask
    task automatic wr(input logic [2:0] d);
        lwe <= 1'b1;
        lwd <= d;
        @(posedge mclk);
        lwe <= 1'b0;
        lm = d;
    endtask

    // Snapshot watcher; released two-wire levels are masked, the wire shows them
    always @(negedge mclk) begin
        if (look) cmp({p_out & (mode[1] ? 3'h2 : 3'h7), p_oe, p_pu, p_lat, o_wf, o_sf, o_irq},
            q.pop_front());
    end
    // Data sample taken at each clock rise during the edge test, once settled
    always @(negedge mclk) begin
        if (o_rise && edg) cmp(15'(o_smp), 15'(dq.pop_front()));
        if (o_fall && edg) falls++;
    end

    initial begin
        #400000;
        fail_count++;
        results();
    end

    initial begin
        logic [7:0] d;
        logic [2:0] r;
        cyc(5);
        rst_b <= 1'b1;
        chk(1);
        cyc(4);
        chk(0);
        for (int i = 0; i < 48; i++) begin
            r = 3'($random(seed));
            if (i % 4 >= 2) r[0] = 1'b0; // Own SDA drive would fake a start
            mode <= 2'(i % 4);
            dir <= r;
            sh <= 1'($random(seed));
            en <= 1'($random(seed));
            gie <= 1'($random(seed));
            wr(3'($random(seed)));
            cyc(5);
            chk(0);
        end
        $display("test modes done");
        mode <= USW_WM_TWO;
        dir <= 3'h4;
        wr(3'h0);
        cyc(5);
        dir <= 3'h5;
        for (int k = 0; k < 4; k++) begin
            sh <= k[0];
            wr({2'h0, k[1]});
            cyc(5);
            chk(0);
        end
        dir <= 3'h4;
        $display("test data drive done");
        for (int k = 0; k < 4; k++) begin
            en <= k[0];
            gie <= k[1];
            mode <= k[1] ? USW_WM_TWO_HOLD : USW_WM_TWO;
            wr(3'h4);
            pulse(0);
            wf = 1'b1;
            cyc(5);
            chk(0);
            en <= 1'b1;
            gie <= 1'b1;
            cyc(5);
            chk(0);
            wev <= 1'b1;
            wclr <= 1'b1;
            cyc(1);
            wev <= 1'b0;
            wclr <= 1'b0;
            cyc(5);
            chk(0);
            pulse(1);
            wf = 1'b0;
            cyc(5);
            chk(0);
        end
        $display("test wrap done");
        mode <= USW_WM_TWO_HOLD;
        cyc(5);
        usw_bus_peer_inst.start_cond();
        sf = 1'b1;
        cyc(5);
        chk(0);
        pulse(0);
        wf = 1'b1;
        pulse(2);
        sf = 1'b0;
        cyc(5);
        chk(0);
        wr(3'h0);
        pulse(1);
        wf = 1'b0;
        cyc(5);
        chk(0);
        wr(3'h4);
        cyc(5);
        chk(0);
        mode <= USW_WM_OFF;
        cyc(5);
        usw_bus_peer_inst.start_cond();
        cyc(5);
        chk(0);
        $display("test start hold done");
        mode <= USW_WM_THREE;
        lwe <= 1'b1;
        lwd <= 3'h5;
        tgl <= 1'b1;
        cyc(1);
        lwe <= 1'b0;
        tgl <= 1'b0;
        lm = 3'h1;
        cyc(5);
        chk(0);
        pulse(3);
        lm = lm ^ 3'h4;
        cyc(5);
        chk(0);
        $display("test toggle done");
        for (int m = 0; m < 4; m++) begin
            mode <= 2'(m);
            dir <= 3'h0;
            cyc(6);
            edg <= 1'b1;
            d = 8'($random(seed));
            for (int b = 7; b >= 0; b--) dq.push_back(d[b]);
            usw_bus_peer_inst.clocks(d);
            cyc(6);
            edg <= 1'b0;
            cmp(15'(falls), 15'h8);
            cmp(15'(dq.size()), 15'h0);
            falls = 0;
        end
        $display("test inputs done");
        mode <= USW_WM_TWO_HOLD;
        dir <= 3'h4;
        pulse(0);
        rst_b <= 1'b0;
        lm = 3'h0;
        wf = 1'b0;
        sf = 1'b0;
        cyc(3);
        chk(1);
        rst_b <= 1'b1;
        cyc(5);
        chk(0);
        $display("test reset done");
        results();
    end
endmodule
